/* File: tb/cmi_bench.sv */
/*
 Self-checking bench: AHB-Lite tasks order the link master, which talks to
 the cell monitor slave. Assumes the design files under verilog/.
*/
`timescale 1ns/1ps
`default_nettype none
module cmi_bench;
	localparam int LK_S = 200;
	localparam int LK_L = 400;
	logic mclk, srst, ce_host, wake_th, wake_rel, lk_long, hwrite, hresp;
	logic hreadyout, sleep_mode, monitor_en;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] tap_switches, balance_switches, got;
	int fails, n_checks, n;
	cmi_if cmi_if_inst ();
	cmi_dev #(.LOCK_SHORT(LK_S), .LOCK_LONG(LK_L)) cmi_dev_inst (
		.mclk(mclk), .srst(srst), .ce(1'b1), .lnk(cmi_if_inst.dev),
		.wake_above_th(wake_th), .wake_above_rel(wake_rel),
		.lockup_long(lk_long), .sleep_mode(sleep_mode), .monitor_en(monitor_en),
		.tap_switches(tap_switches), .balance_switches(balance_switches));
	cmi_host cmi_host_inst (.mclk(mclk), .srst(srst), .ce(ce_host),
		.hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.lnk(cmi_if_inst.host));
	cmi_link_props #(.LOCK_SHORT(LK_S), .LOCK_LONG(LK_L)) cmi_link_props_inst (
		.mclk(mclk), .srst(srst), .scl(cmi_if_inst.scl), .sda(cmi_if_inst.sda),
		.dev_sda_oe_n(cmi_if_inst.dev_sda_oe_n),
		.host_sda_oe_n(cmi_if_inst.host_sda_oe_n));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		if (fails == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	// One link transfer; polls the master until it is no longer busy
	task automatic dev_op(input logic rd, input logic [7:0] idx,
		input logic [7:0] dat, input logic nk);
		logic [31:0] r;
		int i;
		ahb(1'b1, cmi_pkg::HOST_CMD, {15'h0, rd, idx, dat}, r);
		i = 0;
		r = 32'h1;
		while (r[cmi_pkg::ST_BUSY_BIT] !== 1'b0 && i < 3000) begin
			ahb(1'b0, cmi_pkg::HOST_STAT, 32'h0, r);
			i++;
		end
		if (i >= 3000)
			fails++;
		chk(r[cmi_pkg::ST_NACK_BIT], nk);
		got = r[15:8];
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
		dev_op(1'b0, idx, dat, 1'b0);
	endtask
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
		dev_op(1'b1, idx, 8'h00, 1'b0);
		chk(got, exp);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{srst, ce_host, wake_th, wake_rel, lk_long, hwrite, htrans} = 8'hC0;
		{haddr, hwdata, hsize} = {64'h0, 3'b010};
		{fails, n_checks} = 0;
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		repeat (4) @(posedge mclk);
		chk({sleep_mode, monitor_en, tap_switches, balance_switches}, 0);
		rd_chk(cmi_pkg::IDX_SMC, cmi_pkg::SMC_RST);
		rd_chk(cmi_pkg::IDX_BSC, cmi_pkg::BSC_RST);
		wr(8'h02, 8'hFF);
		rd_chk(8'h02, 8'h00);
		// Every tap code, reserved bits set to show they steer nothing
		for (int k = 0; k < 8; k++) begin
			wr(cmi_pkg::IDX_SMC, 8'h38 | k[7:0]);
			rd_chk(cmi_pkg::IDX_SMC, 8'h38 | k[7:0]);
			chk({monitor_en, tap_switches}, {1'b1, 8'h01 << k});
		end
		wr(cmi_pkg::IDX_SMC, 8'h1F);
		chk({monitor_en, tap_switches}, 0);
		wr(cmi_pkg::IDX_BSC, 8'hA5);
		rd_chk(cmi_pkg::IDX_BSC, 8'hA5);
		chk(balance_switches, 8'hA5);
		// No two neighbouring switches on at once
		wr(cmi_pkg::IDX_BSC, 8'h4A);
		chk(balance_switches, 8'h4A);
		// Freeze the master in the address ack: the slave must give up alone
		for (int f = 0; f < 2; f++) begin
			lk_long <= f[0];
			fork
				dev_op(1'b0, cmi_pkg::IDX_BSC, 8'h00, 1'b1);
				begin
					n = 0;
					while (cmi_if_inst.dev_sda_oe_n !== 1'b0 && n < 2000) begin
						@(posedge mclk);
						n++;
					end
					ce_host <= 1'b0;
					n = 0;
					while (cmi_if_inst.dev_sda_oe_n !== 1'b1 && n < 1000) begin
						@(posedge mclk);
						n++;
					end
					chk(n > (f ? LK_L : LK_S) - 8 && n < (f ? LK_L : LK_S) + 8, 1);
					repeat (20) @(posedge mclk);
					ce_host <= 1'b1;
				end
			join
			rd_chk(cmi_pkg::IDX_BSC, 8'h4A);
		end
		wr(cmi_pkg::IDX_SMC, 8'hA0);
		chk({sleep_mode, monitor_en, tap_switches, balance_switches}, 18'h20000);
		rd_chk(cmi_pkg::IDX_BSC, 8'h00);
		rd_chk(cmi_pkg::IDX_SMC, 8'hA0);
		// A wake pulse shorter than the qualification time is ignored
		wake_rel <= 1'b1;
		wake_th <= 1'b1;
		repeat (500) @(posedge mclk);
		wake_th <= 1'b0;
		repeat (20) @(posedge mclk);
		chk(sleep_mode, 1'b1);
		wake_th <= 1'b1;
		repeat (1100) @(posedge mclk);
		chk(sleep_mode, 1'b0);
		rd_chk(cmi_pkg::IDX_SMC, 8'h60);
		wr(cmi_pkg::IDX_SMC, 8'h80);
		rd_chk(cmi_pkg::IDX_SMC, 8'h40);
		chk(sleep_mode, 1'b0);
		wake_th <= 1'b0;
		wake_rel <= 1'b0;
		repeat (10) @(posedge mclk);
		rd_chk(cmi_pkg::IDX_SMC, 8'h00);
		wr(cmi_pkg::IDX_SMC, 8'h40);
		rd_chk(cmi_pkg::IDX_SMC, 8'h00);
		// Host-written wake still blocks a sleep request until cleared
		wr(cmi_pkg::IDX_SMC, 8'h80);
		chk(sleep_mode, 1'b0);
		wr(cmi_pkg::IDX_SMC, 8'h00);
		wr(cmi_pkg::IDX_SMC, 8'h80);
		chk(sleep_mode, 1'b1);
		wr(cmi_pkg::IDX_SMC, 8'h00);
		chk(sleep_mode, 1'b0);
		wrap_up;
	end
	// Tests need some 30k cycles; twice that means a hang
	initial begin
		#600000;
		fails++;
		wrap_up;
	end
endmodule // cmi_bench
`default_nettype wire

/* File: tb/cmi_link_props.sv */
/*
 Concurrent checks on the two-wire link between master and slave.
 Assumes the link lines change only on mclk edges (both ends are flops).
*/
`timescale 1ns/1ps
`default_nettype none
module cmi_link_props #(
	parameter int LOCK_SHORT = 200,
	parameter int LOCK_LONG = 400
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Link lines and drivers
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_oe_n,
	input wire logic host_sda_oe_n
);
	logic scl_p, sda_p, busy_q, match_q, rd_q;
	logic [3:0] bit_n;
	logic [7:0] byte_n, sh;
	int lk_cnt;
	wire start_ev = scl && scl_p && sda_p && !sda;
	wire stop_ev = scl && scl_p && !sda_p && sda;
	wire rise_ev = scl && !scl_p;
	////////////////////////////////////////////////////////////////////////
	// Bus tracker; a lockup drops the match after LOCK_SHORT cycles, the slave goes idle then or, with the long fuse, after LOCK_LONG
	always_ff @(posedge mclk) begin
		if (srst) begin
			{scl_p, sda_p, busy_q, match_q, rd_q} <= 5'h18;
			{bit_n, byte_n, sh} <= 20'h0;
			lk_cnt <= 0;
		end else begin
			scl_p <= scl;
			sda_p <= sda;
			lk_cnt <= (start_ev || (scl_p && !scl) || !busy_q) ? 0 : lk_cnt + 1;
			if (start_ev) begin
				busy_q <= 1'b1;
				bit_n <= 4'h0;
				byte_n <= 8'h0;
				match_q <= 1'b0;
			end else if (stop_ev) begin
				busy_q <= 1'b0;
			end else if (lk_cnt == LOCK_SHORT) begin
				match_q <= 1'b0;
			end else if (rise_ev) begin
				if (bit_n == 4'h8) begin
					bit_n <= 4'h0;
					byte_n <= byte_n + 8'h1;
				end else begin
					sh <= {sh[6:0], sda};
					bit_n <= bit_n + 4'h1;
					if (bit_n == 4'h7 && byte_n == 8'h0) begin
						match_q <= (sh[6:0] == cmi_pkg::SLV_ADDR);
						rd_q <= sda;
					end
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	a_dev_sda_stable: assert property (scl && scl_p && lk_cnt < LOCK_SHORT
		|-> $stable(dev_sda_oe_n)) else $error("slave moved SDA with SCL high");
	a_addr_ack_match: assert property (rise_ev && bit_n == 4'h8 && byte_n == 8'h0
		|-> dev_sda_oe_n == !match_q) else $error("address ack wrong");
	a_write_ack_low: assert property (rise_ev && bit_n == 4'h8 && byte_n != 8'h0
		&& match_q && !rd_q |-> !dev_sda_oe_n) else $error("write byte not acked");
	a_read_nack_free: assert property (rise_ev && bit_n == 4'h8 && byte_n != 8'h0
		&& match_q && rd_q |-> dev_sda_oe_n) else $error("slave held master ack");
	a_wbits_quiet: assert property (busy_q && !rd_q && byte_n != 8'h0
		&& bit_n != 4'h0 && bit_n != 4'h8 |-> dev_sda_oe_n)
		else $error("slave drove during write data");
	a_addr_quiet: assert property (busy_q && byte_n == 8'h0 && bit_n != 4'h8
		|-> dev_sda_oe_n) else $error("slave drove during address");
	a_idle_free: assert property (!busy_q |-> dev_sda_oe_n)
		else $error("slave drove idle bus");
	a_lockup_release: assert property (busy_q && lk_cnt >= LOCK_LONG + 8
		|-> dev_sda_oe_n) else $error("lockup did not release SDA");
	a_ack_alone: assert property (!dev_sda_oe_n && scl |-> host_sda_oe_n)
		else $error("both ends drive SDA");
endmodule // cmi_link_props
`default_nettype wire

/* File: verilog/cmi_dev.sv */
/*
 Cell monitor two-wire slave with its sleep/monitor and balance registers.
 Assumes SCL, SDA and the analog comparator levels are asynchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module cmi_dev #(
	parameter int LOCK_SHORT = cmi_pkg::LOCK_SHORT_CYC,
	parameter int LOCK_LONG = cmi_pkg::LOCK_LONG_CYC
) (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	// Link
	cmi_if.dev lnk,
	// Comparators and trim fuse
	input wire logic wake_above_th,
	input wire logic wake_above_rel,
	input wire logic lockup_long,
	// Analog controls
	output logic sleep_mode,
	output logic monitor_en,
	output logic [7:0] tap_switches,
	output logic [7:0] balance_switches
);

////////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		S_IDLE, S_RX, S_RACK, S_TX, S_TACK
	} cmi_dst_t;

	localparam int QW = $clog2(cmi_pkg::WAKE_QUAL_CYC + 1);

	logic [4:0] s1_q;
	logic [4:0] s2_q;
	logic scl_p_q;
	logic sda_p_q;
	logic scl;
	logic sda;
	logic start;
	logic stop;
	logic scl_rise;
	logic scl_fall;
	cmi_dst_t st_q, st_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d;
	logic [1:0] nb_q, nb_d;
	logic rw_q, rw_d;
	logic [7:0] idx_q, idx_d;
	logic oen_q, oen_d;
	logic [22:0] tmr_q, tmr_d;
	logic [22:0] lim;
	logic ton_q, ton_d;
	logic wr_now;
	logic slp_q, slp_d;
	logic wake_q, wake_d;
	logic hwake_q, hwake_d;
	logic mon_q, mon_d;
	logic [1:0] rsv_q, rsv_d;
	logic [2:0] tap_q, tap_d;
	logic [7:0] bal_q, bal_d;
	logic [QW-1:0] qual_q, qual_d;
	logic [7:0] rdata;
	logic slpo_q, slpo_d;
	logic mono_q, mono_d;
	logic [7:0] tapo_q, tapo_d;
	logic [7:0] balo_q, balo_d;

////////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers; edges are found past the second stage
	always_ff @(posedge mclk) begin
		if (srst) begin
			s1_q <= 5'h1F;
			s2_q <= 5'h1F;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else if (ce) begin
			s1_q <= {lockup_long, wake_above_rel, wake_above_th, lnk.sda,
				lnk.scl};
			s2_q <= s1_q;
			scl_p_q <= s2_q[0];
			sda_p_q <= s2_q[1];
		end
	end

	assign scl = s2_q[0];
	assign sda = s2_q[1];
	// SCL high in both samples, so a data change while clock low never counts
	assign start = scl & scl_p_q & sda_p_q & ~sda; // RULE_02
	assign stop = scl & scl_p_q & ~sda_p_q & sda; // RULE_02
	assign scl_rise = scl & ~scl_p_q;
	assign scl_fall = ~scl & scl_p_q;
	assign lim = s2_q[4] ? LOCK_LONG[22:0] : LOCK_SHORT[22:0]; // RULE_08

////////////////////////////////////////////////////////////////////////////
	// Protocol engine
	always_comb begin
		st_d = st_q;
		bit_d = bit_q;
		sh_d = sh_q;
		nb_d = nb_q;
		rw_d = rw_q;
		idx_d = idx_q;
		oen_d = oen_q;
		ton_d = ton_q;
		wr_now = 1'b0;
		tmr_d = ton_q ? tmr_q + 23'h000001 : tmr_q;
		if (scl_fall)
			tmr_d = 23'h000000; // RULE_07
		if (start) begin
			// Repeated start restarts the byte count like a first start
			ton_d = 1'b1; // RULE_07
			tmr_d = 23'h000000;
			st_d = S_RX; // RULE_03
			bit_d = 4'h0;
			nb_d = 2'h0;
			oen_d = 1'b1;
		end else if (stop) begin
			ton_d = 1'b0; // RULE_07
			st_d = S_IDLE;
			oen_d = 1'b1;
		end else if (ton_q && tmr_q >= lim) begin
			// Lines back to idle; registers untouched
			ton_d = 1'b0; // RULE_08
			st_d = S_IDLE;
			oen_d = 1'b1;
		end else begin
			case (st_q)
			S_RX: begin
				if (scl_rise) begin
					sh_d = {sh_q[6:0], sda}; // RULE_04
					bit_d = bit_q + 4'h1;
				end else if (scl_fall && bit_q == 4'h8) begin
					nb_d = (nb_q == 2'h2) ? nb_q : nb_q + 2'h1;
					if (nb_q == 2'h0) begin
						if (sh_q[7:1] == cmi_pkg::SLV_ADDR) begin // RULE_12
							rw_d = sh_q[0]; // RULE_11
							oen_d = 1'b0; // RULE_05
							st_d = S_RACK;
						end else begin
							st_d = S_IDLE;
						end
					end else begin
						if (nb_q == 2'h1)
							idx_d = sh_q; // RULE_10
						else
							wr_now = 1'b1; // RULE_09
						oen_d = 1'b0; // RULE_05
						st_d = S_RACK;
					end
				end
			end
			S_RACK: begin
				if (scl_fall) begin
					bit_d = 4'h0;
					if (rw_q) begin
						sh_d = rdata; // RULE_10
						oen_d = rdata[7]; // RULE_01
						st_d = S_TX;
					end else begin
						oen_d = 1'b1;
						st_d = S_RX;
					end
				end
			end
			S_TX: begin
				if (scl_fall) begin
					bit_d = bit_q + 4'h1;
					if (bit_q == 4'h7) begin
						oen_d = 1'b1;
						st_d = S_TACK;
					end else begin
						sh_d = {sh_q[6:0], 1'b0};
						oen_d = sh_q[6]; // RULE_04
					end
				end
			end
			S_TACK: begin
				if (scl_rise && sda) begin
					st_d = S_IDLE; // RULE_06
				end else if (scl_fall) begin
					bit_d = 4'h0;
					sh_d = rdata;
					oen_d = rdata[7];
					st_d = S_TX;
				end
			end
			default: st_d = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_q <= S_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			nb_q <= 2'h0;
			rw_q <= 1'b0;
			idx_q <= 8'h00;
			oen_q <= 1'b1;
			ton_q <= 1'b0;
			tmr_q <= 23'h000000;
		end else if (ce) begin
			st_q <= st_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			nb_q <= nb_d;
			rw_q <= rw_d;
			idx_q <= idx_d;
			oen_q <= oen_d;
			ton_q <= ton_d;
			tmr_q <= tmr_d;
		end
	end

////////////////////////////////////////////////////////////////////////////
	// Registers and wake qualification
	always_comb begin
		slp_d = slp_q;
		wake_d = wake_q;
		hwake_d = hwake_q;
		mon_d = mon_q;
		rsv_d = rsv_q;
		tap_d = tap_q;
		bal_d = bal_q;
		qual_d = qual_q;
		if (!s2_q[2])
			qual_d = '0;
		else if (qual_q != QW'(cmi_pkg::WAKE_QUAL_CYC))
			qual_d = qual_q + QW'(1);
		if (wr_now && idx_q == cmi_pkg::IDX_SMC) begin // RULE_13
			slp_d = sh_q[cmi_pkg::SLP_BIT] & ~wake_q & ~hwake_q; // RULE_14
			hwake_d = sh_q[cmi_pkg::WAKE_BIT]; // RULE_16
			mon_d = sh_q[cmi_pkg::MON_BIT]; // RULE_18
			rsv_d = sh_q[cmi_pkg::RSV_LSB+:2]; // RULE_24
			tap_d = sh_q[cmi_pkg::TAP_LSB+:3]; // RULE_19
			if (slp_d)
				bal_d = 8'h00; // RULE_21
		end
		if (wr_now && idx_q == cmi_pkg::IDX_BSC)
			bal_d = sh_q; // RULE_20
		if (!s2_q[3])
			wake_d = 1'b0; // RULE_15
		if (s2_q[2] && qual_q == QW'(cmi_pkg::WAKE_QUAL_CYC))
			wake_d = 1'b1; // RULE_15
		// Wake held: sleep bit pinned low until the flag clears
		if (wake_d || hwake_d)
			slp_d = 1'b0; // RULE_14
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			slp_q <= cmi_pkg::SMC_RST[cmi_pkg::SLP_BIT]; // RULE_13
			wake_q <= cmi_pkg::SMC_RST[cmi_pkg::WAKE_BIT];
			hwake_q <= cmi_pkg::SMC_RST[cmi_pkg::WAKE_BIT];
			mon_q <= cmi_pkg::SMC_RST[cmi_pkg::MON_BIT];
			rsv_q <= cmi_pkg::SMC_RST[cmi_pkg::RSV_LSB+:2];
			tap_q <= cmi_pkg::SMC_RST[cmi_pkg::TAP_LSB+:3];
			bal_q <= cmi_pkg::BSC_RST;
			qual_q <= '0;
		end else if (ce) begin
			slp_q <= slp_d;
			wake_q <= wake_d;
			hwake_q <= hwake_d;
			mon_q <= mon_d;
			rsv_q <= rsv_d;
			tap_q <= tap_d;
			bal_q <= bal_d;
			qual_q <= qual_d;
		end
	end

	// Wake bit reads the pin status, never the host-written copy
	always_comb begin
		case (idx_q)
		cmi_pkg::IDX_SMC: rdata = {slp_q, wake_q, mon_q, rsv_q, tap_q}; // RULE_17
		cmi_pkg::IDX_BSC: rdata = bal_q;
		default: rdata = 8'h00;
		endcase
	end

////////////////////////////////////////////////////////////////////////////
	// Analog controls; monitor, taps and balance forced off in sleep
	always_comb begin
		slpo_d = slp_q;
		mono_d = mon_q & ~slp_q; // RULE_23
		tapo_d = mono_d ? 8'h01 << tap_q : 8'h00; // RULE_19
		balo_d = slp_q ? 8'h00 : bal_q; // RULE_23
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			slpo_q <= 1'b0;
			mono_q <= 1'b0;
			tapo_q <= 8'h00;
			balo_q <= 8'h00;
		end else if (ce) begin
			slpo_q <= slpo_d;
			mono_q <= mono_d;
			tapo_q <= tapo_d;
			balo_q <= balo_d;
		end
	end

	assign sleep_mode = slpo_q;
	assign monitor_en = mono_q;
	assign tap_switches = tapo_q;
	assign balance_switches = balo_q;
	assign lnk.dev_sda_oe_n = oen_q;
	assign lnk.dev_sda_o = 1'b0;
endmodule // cmi_dev
`default_nettype wire

/* File: verilog/cmi_host.sv */
/*
 Two-wire bus master for the cell monitor, ordered over AHB-Lite.
 Assumes the slave never stretches SCL; one slave on the AHB bus.
*/
`timescale 1ns/1ps
`default_nettype none
module cmi_host (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Link
	cmi_if.host lnk
);

////////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		H_IDLE, H_START, H_BIT, H_RSTART, H_STOP
	} cmi_hst_t;

	logic wen_q, wen_d;
	logic [7:0] wa_q, wa_d;
	logic [31:0] rd_q, rd_d;
	logic [7:0] div_q, div_d;
	logic [1:0] sy_q;
	logic sda_s;
	logic go;
	logic tick;
	logic rdbyte;
	cmi_hst_t hs_q, hs_d;
	logic [7:0] tc_q, tc_d;
	logic [1:0] qt_q, qt_d;
	logic [3:0] bn_q, bn_d;
	logic [1:0] by_q, by_d;
	logic [7:0] tb_q, tb_d;
	logic [7:0] rx_q, rx_d;
	logic rdop_q, rdop_d;
	logic [7:0] ix_q, ix_d;
	logic [7:0] dt_q, dt_d;
	logic nk_q, nk_d;
	logic [7:0] rdat_q, rdat_d;
	logic busy_q, busy_d;
	logic scl_q, scl_d;
	logic sda_q, sda_d;

////////////////////////////////////////////////////////////////////////////
	// Bus slave: zero wait states, read data registered in address phase
	always_comb begin
		wen_d = hsel & htrans[1] & hready & hwrite & (hsize == 3'h2);
		wa_d = haddr[7:0];
		rd_d = rd_q;
		div_d = div_q;
		if (hsel && htrans[1] && hready && !hwrite) begin
			case (haddr[7:0])
			cmi_pkg::HOST_STAT: rd_d = {16'h0000, rdat_q, 6'h00, nk_q, busy_q};
			cmi_pkg::HOST_DIV: rd_d = {24'h000000, div_q};
			default: rd_d = 32'h00000000;
			endcase
		end
		// Short quarters would outrun the slave's two-stage sampling
		if (wen_q && wa_q == cmi_pkg::HOST_DIV)
			div_d = (hwdata[7:0] < cmi_pkg::DIV_RST) ? cmi_pkg::DIV_RST
				: hwdata[7:0];
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			wen_q <= 1'b0;
			wa_q <= 8'h00;
			rd_q <= 32'h00000000;
			div_q <= cmi_pkg::DIV_RST;
			sy_q <= 2'h3;
		end else if (ce) begin
			wen_q <= wen_d;
			wa_q <= wa_d;
			rd_q <= rd_d;
			div_q <= div_d;
			sy_q <= {sy_q[0], lnk.sda};
		end
	end

	assign sda_s = sy_q[1];
	assign go = wen_q & (wa_q == cmi_pkg::HOST_CMD) & ~busy_q;
	assign tick = (tc_q == div_q - 8'h01);
	assign rdbyte = rdop_q & (by_q == 2'h3);

////////////////////////////////////////////////////////////////////////////
	// Bit engine: four quarters per bit, SDA moved only with SCL low save for start, repeated start and stop
	always_comb begin
		hs_d = hs_q;
		qt_d = qt_q;
		bn_d = bn_q;
		by_d = by_q;
		tb_d = tb_q;
		rx_d = rx_q;
		rdop_d = rdop_q;
		ix_d = ix_q;
		dt_d = dt_q;
		nk_d = nk_q;
		rdat_d = rdat_q;
		busy_d = busy_q;
		scl_d = scl_q;
		sda_d = sda_q;
		tc_d = (tick || hs_q == H_IDLE) ? 8'h00 : tc_q + 8'h01;
		if (go) begin
			rdop_d = hwdata[cmi_pkg::CMD_RD_BIT];
			ix_d = hwdata[cmi_pkg::CMD_IDX_LSB+:8];
			dt_d = hwdata[cmi_pkg::CMD_DAT_LSB+:8];
			tb_d = {cmi_pkg::SLV_ADDR, 1'b0}; // RULE_09
			by_d = 2'h0;
			bn_d = 4'h0;
			qt_d = 2'h0;
			nk_d = 1'b0;
			busy_d = 1'b1;
			hs_d = H_START;
		end else if (tick) begin
			qt_d = qt_q + 2'h1;
			case (hs_q)
			H_START: begin
				if (qt_q == 2'h0)
					sda_d = 1'b0; // RULE_02
				if (qt_q == 2'h2)
					scl_d = 1'b0;
				if (qt_q == 2'h3)
					hs_d = H_BIT;
			end
			H_RSTART: begin
				if (qt_q == 2'h0)
					sda_d = 1'b1;
				if (qt_q == 2'h1)
					scl_d = 1'b1;
				if (qt_q == 2'h2)
					sda_d = 1'b0; // RULE_03
				if (qt_q == 2'h3) begin
					scl_d = 1'b0;
					hs_d = H_BIT;
				end
			end
			H_BIT: begin
				if (qt_q == 2'h0)
					sda_d = (bn_q == 4'h8) | rdbyte | tb_q[7]; // RULE_01 RULE_06
				if (qt_q == 2'h1)
					scl_d = 1'b1;
				if (qt_q == 2'h3) begin
					scl_d = 1'b0;
					if (bn_q != 4'h8) begin
						bn_d = bn_q + 4'h1;
						tb_d = {tb_q[6:0], 1'b1}; // RULE_04
						if (rdbyte)
							rx_d = {rx_q[6:0], sda_s};
					end else begin
						bn_d = 4'h0;
						by_d = by_q + 2'h1;
						case (by_q)
						2'h0: tb_d = ix_q;
						2'h1: tb_d = rdop_q ? {cmi_pkg::SLV_ADDR, 1'b1} : dt_q;
						default: tb_d = 8'hFF;
						endcase
						if (!rdbyte && sda_s) begin
							nk_d = 1'b1;
							hs_d = H_STOP;
						end else if (rdbyte || (!rdop_q && by_q == 2'h2)) begin
							hs_d = H_STOP; // RULE_06 RULE_09
						end else if (rdop_q && by_q == 2'h1) begin
							hs_d = H_RSTART; // RULE_10
						end
					end
				end
			end
			H_STOP: begin
				if (qt_q == 2'h0)
					sda_d = 1'b0;
				if (qt_q == 2'h1)
					scl_d = 1'b1;
				if (qt_q == 2'h2)
					sda_d = 1'b1; // RULE_02
				if (qt_q == 2'h3) begin
					rdat_d = rx_q;
					busy_d = 1'b0;
					hs_d = H_IDLE;
				end
			end
			default: hs_d = H_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			hs_q <= H_IDLE;
			tc_q <= 8'h00;
			qt_q <= 2'h0;
			bn_q <= 4'h0;
			by_q <= 2'h0;
			tb_q <= 8'h00;
			rx_q <= 8'h00;
			rdop_q <= 1'b0;
			ix_q <= 8'h00;
			dt_q <= 8'h00;
			nk_q <= 1'b0;
			rdat_q <= 8'h00;
			busy_q <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce) begin
			hs_q <= hs_d;
			tc_q <= tc_d;
			qt_q <= qt_d;
			bn_q <= bn_d;
			by_q <= by_d;
			tb_q <= tb_d;
			rx_q <= rx_d;
			rdop_q <= rdop_d;
			ix_q <= ix_d;
			dt_q <= dt_d;
			nk_q <= nk_d;
			rdat_q <= rdat_d;
			busy_q <= busy_d;
			scl_q <= scl_d;
			sda_q <= sda_d;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rd_q;
	assign lnk.host_scl_oe_n = scl_q;
	assign lnk.host_sda_oe_n = sda_q;
	assign lnk.host_scl_o = 1'b0;
	assign lnk.host_sda_o = 1'b0;
endmodule // cmi_host
`default_nettype wire

/* File: verilog/cmi_if.sv */
/*
 Two-wire link between the cell monitor slave and its master.
 Assumes pull-ups: a line is low only while some enabled driver drives 0.
*/
`timescale 1ns/1ps
`default_nettype none
interface cmi_if;
	logic host_scl_o;
	logic host_scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic scl;
	logic sda;
	assign scl = host_scl_oe_n | host_scl_o;
	assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
	modport host (input sda, output host_scl_o, output host_scl_oe_n,
		output host_sda_o, output host_sda_oe_n);
endinterface
`default_nettype wire

/* File: verilog/cmi_pkg.sv */
/*
 Shared constants of the cell monitor two-wire slave and its bus master.
 Assumes a 100 MHz mclk on both ends.
*/
`default_nettype none
// How it works
// RULE_01 - SDA changes only while SCL low
// RULE_02 - SDA fall/rise with SCL high: start/stop
// RULE_03 - Busy from start to stop; restart equals start
// RULE_04 - Bytes are eight bits, MSB first, plus acknowledge
// RULE_05 - Addressed receiver acknowledges every byte low
// RULE_06 - Reading master ends with not-acknowledge, then stop
// RULE_07 - Lock-up timer: start runs, SCL fall restarts
// RULE_08 - Time-out releases lines; registers kept; fuse period
// RULE_09 - Write: address, index, one data, stop
// RULE_10 - Read: write index, then read one byte
// RULE_11 - First byte: seven address bits, direction bit
// RULE_12 - Acknowledge only own address 1011100
// RULE_13 - Index 00H and 01H, both clear at reset
// RULE_14 - Sleep bit starts sleep; wake forces it zero
// RULE_15 - Qualified wake pin sets flag; low clears
// RULE_16 - Host clears written wake flag and sleep bit
// RULE_17 - Wake flag reads pin status only
// RULE_18 - Bit 5 enables the cell voltage monitor
// RULE_19 - Tap code k closes tap switch k+1
// RULE_20 - Balance register bits drive eight balance switches
// RULE_21 - Sleep request clears all balance enables
// RULE_22 - Host avoids adjacent balancing and monitoring during balance
// RULE_23 - Accepted sleep shuts all outputs down
// RULE_24 - Reserved bits store but drive nothing
package cmi_pkg;
	localparam logic [6:0] SLV_ADDR = 7'h5C;
	localparam logic [7:0] IDX_SMC = 8'h00;
	localparam logic [7:0] IDX_BSC = 8'h01;
	localparam logic [7:0] SMC_RST = 8'h00;
	localparam logic [7:0] BSC_RST = 8'h00;
	localparam int SLP_BIT = 7;
	localparam int WAKE_BIT = 6;
	localparam int MON_BIT = 5;
	localparam int RSV_LSB = 3;
	localparam int TAP_LSB = 0;
	localparam int CLK_KHZ = 100000;
	localparam int LOCK_SHORT_MS = 32;
	localparam int LOCK_LONG_MS = 64;
	localparam int LOCK_SHORT_CYC = LOCK_SHORT_MS * CLK_KHZ;
	localparam int LOCK_LONG_CYC = LOCK_LONG_MS * CLK_KHZ;
	localparam int WAKE_QUAL_US = 10;
	localparam int WAKE_QUAL_CYC = WAKE_QUAL_US * CLK_KHZ / 1000;
	localparam logic [7:0] HOST_CMD = 8'h00;
	localparam logic [7:0] HOST_STAT = 8'h04;
	localparam logic [7:0] HOST_DIV = 8'h08;
	localparam logic [7:0] DIV_RST = 8'h04;
	localparam int CMD_RD_BIT = 16;
	localparam int CMD_IDX_LSB = 8;
	localparam int CMD_DAT_LSB = 0;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_NACK_BIT = 1;
	localparam int ST_RDAT_LSB = 8;
endpackage
`default_nettype wire
